// [src/fts_top.sv]
// Flash/torch sink control with safety timer and four brightness-coded sinks
`timescale 1ns/1ps
`include "fts_cfg.svh"
module fts_top
	import fts_pkg::*;
#(
	parameter fts_pkg::fts_count_t LIMIT_LONG = fts_pkg::fts_count_t'(`FTS_LIMIT_LONG_CYC),
	parameter fts_pkg::fts_count_t LIMIT_SHORT = fts_pkg::fts_count_t'(`FTS_LIMIT_SHORT_CYC)
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire fts_pkg::fts_byte_t addr,
	input wire fts_pkg::fts_byte_t wr_data,
	output fts_pkg::fts_byte_t rd_data,
	input wire logic trig_pin,
	input wire logic audio_sync_en,
	input wire fts_pkg::fts_byte_t audio_level,
	output logic torch_on,
	output logic flash_on,
	output logic [3:0] sink_on,
	output fts_pkg::fts_byte_t sink_channel_1,
	output fts_pkg::fts_byte_t sink_channel_2,
	output fts_pkg::fts_byte_t sink_channel_3,
	output fts_pkg::fts_byte_t sink_channel_4
);
	import fts_pkg::*;

	// Limits are parameters so a bench need not run for seconds

	////////////////////////////////////////////////////////////////////////
	// Pin synchroniser
	logic trig_meta, trig_sync;
	logic next_trig_meta, next_trig_sync;

	always_comb
	begin
		next_trig_meta = trig_pin;
		next_trig_sync = trig_meta;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			trig_meta <= 1'b0;
			trig_sync <= 1'b0;
		end
		else if (clk_en)
		begin
			trig_meta <= next_trig_meta;
			trig_sync <= next_trig_sync;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers
	fts_byte_t ctrl, next_ctrl;
	fts_byte_t code [4];
	fts_byte_t next_code [4];
	fts_byte_t next_rd_data;

	always_comb
	begin
		next_ctrl = ctrl;
		if (wr_en && addr == `FTS_ADDR_CTRL)
			next_ctrl = wr_data;
		next_rd_data = 8'h00;
		if (rd_en)
		begin
			case (addr)
				`FTS_ADDR_CTRL: next_rd_data = ctrl;
				`FTS_ADDR_CH1: next_rd_data = code[0];
				`FTS_ADDR_CH2: next_rd_data = code[1];
				`FTS_ADDR_CH3: next_rd_data = code[2];
				`FTS_ADDR_CH4: next_rd_data = code[3];
				default: next_rd_data = 8'h00;
			endcase
		end
		else
			next_rd_data = rd_data;
	end

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_code
			// Audio owns channel one; dropped writes are not queued
			always_comb
			begin
				next_code[gi] = code[gi];
				if (wr_en && addr == `FTS_ADDR_CH1 + 8'(gi) && !(gi == 0 && audio_sync_en))
					next_code[gi] = wr_data;
			end

			always_ff @(posedge clk)
			begin
				if (rst)
					code[gi] <= `FTS_CODE_RST;
				else if (clk_en)
					code[gi] <= next_code[gi];
			end
		end
	endgenerate

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ctrl <= `FTS_CTRL_RST;
			rd_data <= 8'h00;
		end
		else if (clk_en)
		begin
			ctrl <= next_ctrl;
			rd_data <= next_rd_data;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Flash state machine and safety timer
	fts_mode_e mode, next_mode;
	fts_count_t cnt, next_cnt;
	logic trig_prev, next_trig_prev;
	logic trig_now;
	logic torch_req;
	fts_count_t limit;

	always_comb
	begin
		trig_now = ctrl[`FTS_BIT_TRIG] | trig_sync;
		limit = ctrl[`FTS_BIT_GUARD] ? LIMIT_SHORT : LIMIT_LONG;
		torch_req = ctrl[`FTS_BIT_TORCH] && !ctrl[`FTS_BIT_ARM];
		next_trig_prev = trig_now;
		next_mode = mode;
		next_cnt = cnt;
		case (mode)
			FTS_OFF, FTS_TORCH:
			begin
				next_cnt = '0;
				if (ctrl[`FTS_BIT_ARM] && trig_now && !trig_prev)
					next_mode = FTS_FLASH;
				else if (ctrl[`FTS_BIT_TORCH] && !ctrl[`FTS_BIT_ARM])
					next_mode = FTS_TORCH;
				else
					next_mode = FTS_OFF;
			end
			FTS_FLASH:
			begin
				next_cnt = cnt + 27'h1;
				// Timeout leaves trigger high; a fresh rise is needed to refire
				if (!ctrl[`FTS_BIT_ARM] || !trig_now || cnt >= limit - 27'h1)
				begin
					// Torch resumes at once if the arm bit went away
					next_mode = torch_req ? FTS_TORCH : FTS_OFF;
					next_cnt = '0;
				end
			end
			default:
			begin
				next_mode = FTS_OFF;
				next_cnt = '0;
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			mode <= FTS_OFF;
			cnt <= '0;
			trig_prev <= 1'b0;
		end
		else if (clk_en)
		begin
			mode <= next_mode;
			cnt <= next_cnt;
			trig_prev <= next_trig_prev;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	logic next_torch_on, next_flash_on;
	logic [3:0] next_sink_on;
	fts_byte_t next_ch [4];
	fts_byte_t ch_q [4];

	always_comb
	begin
		next_torch_on = (next_mode == FTS_TORCH);
		next_flash_on = (next_mode == FTS_FLASH);
		next_sink_on = next_ctrl[3:0];
		for (int i = 0; i < 4; i++)
			next_ch[i] = next_ctrl[i] ? next_code[i] : 8'h00;
		if (audio_sync_en && next_ctrl[0])
			next_ch[0] = audio_level;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			torch_on <= 1'b0;
			flash_on <= 1'b0;
			sink_on <= 4'h0;
			for (int i = 0; i < 4; i++)
				ch_q[i] <= 8'h00;
		end
		else if (clk_en)
		begin
			torch_on <= next_torch_on;
			flash_on <= next_flash_on;
			sink_on <= next_sink_on;
			for (int i = 0; i < 4; i++)
				ch_q[i] <= next_ch[i];
		end
	end

	assign sink_channel_1 = ch_q[0];
	assign sink_channel_2 = ch_q[1];
	assign sink_channel_3 = ch_q[2];
	assign sink_channel_4 = ch_q[3];
endmodule

// [src/fts_cfg.svh]
// Register offsets, field positions, reset values and timing counts for the flash and sink block
`ifndef FTS_CFG_SVH
`define FTS_CFG_SVH
`define FTS_ADDR_CTRL 8'h00
`define FTS_ADDR_CH1 8'h01
`define FTS_ADDR_CH2 8'h02
`define FTS_ADDR_CH3 8'h03
`define FTS_ADDR_CH4 8'h04
`define FTS_BIT_TORCH 4
`define FTS_BIT_ARM 5
`define FTS_BIT_TRIG 6
`define FTS_BIT_GUARD 7
`define FTS_CTRL_RST 8'h00
`define FTS_CODE_RST 8'h00
`define FTS_CLK_HZ 40000000
`define FTS_LIMIT_LONG_MS 2000
`define FTS_LIMIT_SHORT_MS 1000
`define FTS_LIMIT_LONG_CYC (`FTS_LIMIT_LONG_MS * (`FTS_CLK_HZ / 1000))
`define FTS_LIMIT_SHORT_CYC (`FTS_LIMIT_SHORT_MS * (`FTS_CLK_HZ / 1000))
`endif

// [src/fts_pkg.sv]
// Types for the flash and sink block
package fts_pkg;
	typedef logic [7:0] fts_byte_t;
	typedef logic [26:0] fts_count_t;
	typedef enum logic [2:0]
	{
		FTS_OFF = 3'b001,
		FTS_TORCH = 3'b010,
		FTS_FLASH = 3'b100
	} fts_mode_e;
endpackage

// [verif/fts_chk_sva.sv]
// Checker for the flash and sink block
`timescale 1ns/1ps
module fts_chk
(
	input wire logic clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic wr_en,
	input wire fts_pkg::fts_byte_t addr,
	input wire fts_pkg::fts_byte_t wr_data,
	input wire logic trig_pin,
	input wire logic torch_on,
	input wire logic flash_on,
	input wire logic [3:0] sink_on
);
wire w0 = clk_en && wr_en && addr == 8'h00;
default clocking @(posedge clk); endclocking
default disable iff (rst);
chk_sink_bits: assert property (w0 |=> sink_on == $past(wr_data[3:0]))
	else $error("sink bits");
chk_sink_hold: assert property (!w0 |=> $stable(sink_on))
	else $error("sink hold");
// Mode follows the control byte one cycle after it lands
chk_torch_mode: assert property (w0 && wr_data[5:4] == 2'b01 |-> ##2 torch_on && !flash_on)
	else $error("torch");
chk_all_off: assert property (w0 && wr_data[5:4] == 2'b00 |-> ##2 !torch_on && !flash_on)
	else $error("off");
chk_flash_fire: assert property ((!trig_pin && w0 && !wr_data[6])
	##1 !(w0 && wr_data[6]) ##1 (w0 && wr_data[6:5] == 2'b11)
	|-> ##2 flash_on && !torch_on) else $error("fire");
chk_arm_drop: assert property (w0 && !wr_data[5] |-> ##2 !flash_on)
	else $error("arm");
chk_trig_fall: assert property (!trig_pin[*3] ##0 (flash_on && w0 && !wr_data[6])
	|-> ##2 !flash_on) else $error("fall");
chk_one_mode: assert property (!(torch_on && flash_on))
	else $error("both");
cov_torch: cover property (w0 ##1 torch_on);
cov_flash: cover property ($rose(flash_on));
cov_pin: cover property ($rose(trig_pin) ##[1:4] flash_on);
endmodule
bind fts_top fts_chk u_chk (.clk, .rst, .clk_en, .wr_en, .addr, .wr_data, .trig_pin,
	.torch_on, .flash_on, .sink_on);

// [verif/fts_host.sv]
// Host model issuing register cycles
`timescale 1ns/1ps
module fts_host
(
	input wire logic clk,
	output logic wr_en = 1'b0,
	output logic rd_en = 1'b0,
	output logic [7:0] addr = 8'h00,
	output logic [7:0] wr_data = 8'h00
);
// Arm and trigger share the control byte, so one write can set both
// Idle cycle after each strobe so back-to-back calls never re-raise it at once
task automatic wr(logic [7:0] a, logic [7:0] d);
	addr = a;
	wr_data = d;
	wr_en = 1'b1;
	@(negedge clk);
	wr_en = 1'b0;
	wr_data = ~d;
	@(negedge clk);
endtask
task automatic rd(logic [7:0] a);
	addr = a;
	rd_en = 1'b1;
	@(negedge clk);
	rd_en = 1'b0;
	addr = ~a;
	@(negedge clk);
endtask
endmodule

// [verif/fts_top_tb.sv]
// Testbench for the flash and sink block
`timescale 1ns/1ps
module fts_top_tb;
logic clk = 1'b0;
logic rst = 1'b1;
logic trig_pin = 1'b0;
logic audio_sync_en = 1'b0;
logic [7:0] audio_level = 8'h5a;
logic wr_en, rd_en, torch_on, flash_on;
logic [7:0] addr, wr_data, rd_data, sink_channel_1, sink_channel_2, sink_channel_3;
logic [7:0] sink_channel_4;
logic clk_en = 1'b1;
// Short safety limits keep the run brief; ratio matches the guard bit
localparam int LIM_L = 40;
localparam int LIM_S = 20;
logic [3:0] sink_on;
int num_errors = 0;
int n_checks = 0;
always #12.5 clk = ~clk;
fts_host host (.*);
fts_top #(.LIMIT_LONG(27'(LIM_L)), .LIMIT_SHORT(27'(LIM_S))) dut (.*);
task automatic check(string s, logic [7:0] g, logic [7:0] e);
	n_checks++;
	if (g !== e)
	begin
		num_errors++;
		$display("mismatch %s expected %h seen %h", s, e, g);
	end
endtask
task tally_and_finish;
	$display("checks %0d mismatches %0d", n_checks, num_errors);
	if (num_errors == 0 && n_checks > 0)
		$display("Result: passed");
	else
		$display("Result: failed");
	$finish;
endtask
task t_sinks;
	for (int i = 0; i < 6; i++)
	begin
		host.rd(8'(i));
		check("reset rd", rd_data, 8'h00);
	end
	for (int i = 1; i < 5; i++)
		host.wr(8'(i), 8'(i * 'h55));
	host.wr(8'h00, 8'h0a);
	check("sink_on", {4'h0, sink_on}, 8'h0a);
	check("ch1 off", sink_channel_1, 8'h00);
	check("ch2 on", sink_channel_2, 8'haa);
	check("ch4 on", sink_channel_4, 8'h54);
	host.wr(8'h00, 8'h0f);
	check("ch3", sink_channel_3, 8'hff);
	host.rd(8'h00);
	check("ctrl rd", rd_data, 8'h0f);
	audio_sync_en = 1'b1;
	host.wr(8'h01, 8'h77);
	check("ch1 audio", sink_channel_1, 8'h5a);
	audio_sync_en = 1'b0;
	host.rd(8'h01);
	check("ch1 code", rd_data, 8'h55);
	check("ch1 out", sink_channel_1, 8'h55);
endtask
task t_freeze;
	clk_en = 1'b0;
	host.wr(8'h00, 8'h00);
	check("frozen", {4'h0, sink_on}, 8'h0f);
	clk_en = 1'b1;
endtask
task t_flash;
	host.wr(8'h00, 8'h8f);
	check("no torch", {7'h0, torch_on}, 8'h00);
	host.wr(8'h00, 8'h9f);
	check("torch", {7'h0, torch_on}, 8'h01);
	host.wr(8'h00, 8'hff);
	check("flash", {6'h0, torch_on, flash_on}, 8'h01);
	host.wr(8'h00, 8'hbf);
	check("flash end", {6'h0, torch_on, flash_on}, 8'h00);
endtask
task t_timeout;
	int n;
	n = 0;
	host.wr(8'h00, 8'hff);
	while (flash_on === 1'b1 && n < 1000)
	begin
		n++;
		@(negedge clk);
	end
	check("short limit", 8'(n), 8'(LIM_S));
	repeat (3) @(negedge clk);
	check("no refire", {7'h0, flash_on}, 8'h00);
	host.wr(8'h00, 8'h3f);
	host.wr(8'h00, 8'h7f);
	n = 0;
	while (flash_on === 1'b1 && n < 1000)
	begin
		n++;
		@(negedge clk);
	end
	check("long limit", 8'(n), 8'(LIM_L));
endtask
task t_pin;
	host.wr(8'h00, 8'h20);
	trig_pin = 1'b1;
	repeat (4) @(negedge clk);
	check("pin flash", {7'h0, flash_on}, 8'h01);
	host.wr(8'h00, 8'h00);
	check("arm drop", {7'h0, flash_on}, 8'h00);
	check("all off", {7'h0, torch_on}, 8'h00);
	trig_pin = 1'b0;
endtask
initial
begin
	repeat (2) @(negedge clk);
	rst = 1'b0;
	t_sinks;
	t_freeze;
	t_flash;
	t_timeout;
	t_pin;
	tally_and_finish;
end
initial
begin
	#50000;
	num_errors++;
	tally_and_finish;
end
endmodule
